// >>> shared/txm_pkg.sv
// Shared constants and carrier types of the switch message transmitter.
package txm_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	localparam int MEM_WORDS = 16;
	localparam int NUM_PATHS = 4;
	// Buffer 0 holds words 0..5, buffer 1 words 6..11, scratch 12..15
	localparam logic [3:0] BUF1_BASE = 4'h6;
	localparam logic [3:0] SCRATCH_BASE = 4'hc;
	localparam logic [2:0] MAX_DATA_WORDS = 3'h5;
	localparam int HDR_CNT_LSB = 0;
	localparam int HDR_CNT_W = 3;
	localparam logic [ADDR_W-1:0] OFS_MEM_LAST = 5'h0f;
	localparam logic [ADDR_W-1:0] OFS_PEND = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h11;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h12;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_BUF_BIT = 1;
	localparam int ST_PATH_LSB = 2;
	localparam int ST_STOP_BIT = 4;
	localparam logic [3:0] RST_MASK = 4'hf;
	localparam logic [1:0] RST_PATH = 2'h3;
	localparam logic [1:0] RST_PEND = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_ROUTE,
		ST_DATA,
		ST_CSUM,
		ST_FINISH
	} tx_state_type;

	typedef enum logic [2:0] {
		SRC_ZERO,
		SRC_MEM,
		SRC_SHIFT,
		SRC_ROUTE,
		SRC_CSUM,
		SRC_ONES
	} src_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] byteEn;
		logic wr;
		logic rd;
	} bus_req_type;

	typedef struct packed {
		logic [3:0] data;
		logic frame;
		logic ignore;
	} link_out_type;

	typedef struct packed {
		logic reject;
		logic stopSend;
	} link_in_type;
endpackage

// >>> hdl/path_rotator.sv
// Picks the next enabled switch path in cyclic order.
`timescale 1ns/1ps
module path_rotator #(
	parameter int NUM_PATHS = 4
) (
	input wire logic [1:0] curPath, // Path of the previous attempt
	input wire logic [NUM_PATHS-1:0] mask, // One enable bit per path
	output logic [1:0] nextPath, // Path for the next attempt
	output logic anyEnabled // At least one path usable
);
	logic [1:0] cand;

	// Larger steps are tried first so the nearest enabled path wins
	always_comb begin
		cand = '0;
		nextPath = curPath;
		for (int k = NUM_PATHS; k >= 1; k--) begin
			cand = curPath + 2'(k);
			if (mask[cand]) begin
				nextPath = cand;
			end
		end
		anyEnabled = |mask;
	end
endmodule

// >>> hdl/switch_message_transmitter.sv
// Switch message transmitter: two output buffers, path choice, resend.
`timescale 1ns/1ps
//Contract
// - From idle the transmitter starts sending any pending buffer while at least one path is enabled.
// - A completed message clears its buffer's pending flag.
// - A rejected message is resent by hardware and its buffer stays pending.
// - Checksum and routing path are produced by the transmitter itself.
// - With both buffers pending each rejection switches to the other one.
// - Each attempt takes a different one of the four alternate paths while more than one path is enabled.
// - A four-bit mask inhibits paths and an inhibited path is never used.
// - Messages live in a sixteen word by sixteen bit dual-port memory.
// - The controller reads any word and writes its low, high or both bytes.
// - Twelve words form the two buffers and four are scratch storage.
// - Each nibble comes from zero, memory, shifted memory, route, sum, ones.
// - A word not yet written is covered by nibbles flagged to be ignored.
// - A rejection ends the message in progress at once.
// - While the far end says stop, only ignored nibbles are sent.
module switch_message_transmitter
	import txm_pkg::*;
(
	input wire logic clock, // 50 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire bus_req_type busReq, // Register and memory port
	output logic [DATA_W-1:0] rdData, // Read data, one cycle after read
	input wire link_in_type linkIn, // Reject and stop lines from switch
	output link_out_type linkOut // Nibble, frame and ignore to switch
);
	typedef struct packed {
		tx_state_type state;
		logic curBuf;
		logic [1:0] path;
		logic [2:0] wordIdx;
		logic [1:0] nibIdx;
		logic [3:0] csum;
		logic [1:0] pend;
		logic [1:0][2:0] fill;
		logic [3:0] mask;
		logic [2:0] rejSync;
		logic [2:0] stopSync;
		logic rejF;
		logic stopF;
		link_out_type link;
		logic [DATA_W-1:0] rdData;
	} tx_regs_type;

	tx_regs_type r;
	tx_regs_type n;
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [1:0] nextPath;
	logic anyPath;
	logic [1:0] pendSet;
	logic [1:0] pendClr;
	logic [DATA_W-1:0] curWord;
	logic [2:0] lastIdx;
	logic haveWord;
	logic [3:0] dataNib;
	logic [3:0] emitNib;
	logic emit;
	logic starve;
	logic goNow;
	logic memWr;
	logic [2:0] wIdx;
	logic sending;

	function automatic logic [3:0] bufWord(input logic b,
		input logic [2:0] idx);
		return b ? BUF1_BASE + {1'b0, idx} : {1'b0, idx};
	endfunction

	function automatic logic [2:0] bufIdx(input logic [3:0] a);
		return (a >= BUF1_BASE) ? 3'(a - BUF1_BASE) : a[2:0];
	endfunction

	function automatic logic [2:0] hdrWords(input logic [DATA_W-1:0] w);
		logic [2:0] c;
		c = w[HDR_CNT_LSB +: HDR_CNT_W];
		return (c > MAX_DATA_WORDS) ? MAX_DATA_WORDS : c;
	endfunction

	function automatic logic [3:0] nibbleOf(input src_type src,
		input logic [DATA_W-1:0] w, input logic [1:0] idx,
		input logic [1:0] p, input logic [3:0] sum);
		logic [DATA_W-1:0] sh;
		sh = w >> {idx, 2'b00};
		case (src)
			SRC_ZERO: return 4'h0;
			SRC_MEM: return w[3:0];
			SRC_SHIFT: return sh[3:0];
			SRC_ROUTE: return 4'h1 << p;
			SRC_CSUM: return sum;
			SRC_ONES: return 4'hf;
			default: return 4'h0;
		endcase
	endfunction

	path_rotator #(
		.NUM_PATHS(NUM_PATHS)
	) u_path_rotator (
		.curPath(r.path),
		.mask(r.mask),
		.nextPath(nextPath),
		.anyEnabled(anyPath)
	);

	assign memWr = busReq.wr && (busReq.addr <= OFS_MEM_LAST);
	assign wIdx = bufIdx(busReq.addr[3:0]);
	assign curWord = mem[bufWord(r.curBuf, r.wordIdx)];
	assign lastIdx = hdrWords(mem[bufWord(r.curBuf, 3'h0)]);
	assign haveWord = r.wordIdx < r.fill[r.curBuf];
	assign sending = r.state != ST_IDLE;
	assign dataNib = nibbleOf((r.nibIdx == 2'h0) ? SRC_MEM : SRC_SHIFT,
		curWord, r.nibIdx, r.path, r.csum);
	assign starve = (r.state == ST_DATA) && (r.nibIdx == 2'h0) && !haveWord;

	// Both controller ports share the array; the link side only reads it
	always_ff @(posedge clock) begin
		if (memWr) begin
			if (busReq.byteEn[0]) begin
				mem[busReq.addr[3:0]][7:0] <= busReq.wdata[7:0];
			end
			if (busReq.byteEn[1]) begin
				mem[busReq.addr[3:0]][15:8] <= busReq.wdata[15:8];
			end
		end
	end

	always_comb begin
		n = r;
		pendSet = '0;
		pendClr = '0;
		emit = 1'b0;
		emitNib = 4'h0;
		goNow = 1'b0;
		n.link = '0;
		n.rdData = '0;
		n.rejSync = {r.rejSync[1:0], linkIn.reject};
		n.stopSync = {r.stopSync[1:0], linkIn.stopSend};
		if (r.rejSync[1] == r.rejSync[2]) begin
			n.rejF = r.rejSync[2];
		end
		if (r.stopSync[1] == r.stopSync[2]) begin
			n.stopF = r.stopSync[2];
		end
		if (busReq.rd) begin
			if (busReq.addr <= OFS_MEM_LAST) begin
				n.rdData = mem[busReq.addr[3:0]];
			end else if (busReq.addr == OFS_PEND) begin
				n.rdData = {14'h0000, r.pend};
			end else if (busReq.addr == OFS_MASK) begin
				n.rdData = {12'h000, r.mask};
			end else if (busReq.addr == OFS_STATUS) begin
				n.rdData[ST_BUSY_BIT] = sending;
				n.rdData[ST_BUF_BIT] = r.curBuf;
				n.rdData[ST_PATH_LSB +: 2] = r.path;
				n.rdData[ST_STOP_BIT] = r.stopF;
			end
		end
		if (busReq.wr && busReq.addr == OFS_MASK) begin
			n.mask = busReq.wdata[3:0];
		end
		if (busReq.wr && busReq.addr == OFS_PEND) begin
			pendSet = busReq.wdata[1:0];
		end

		case (r.state)
			ST_IDLE: begin
				if ((|r.pend) && anyPath) begin
					goNow = 1'b1;
					n.curBuf = r.pend[r.curBuf] ? r.curBuf : ~r.curBuf;
					n.path = nextPath;
					n.wordIdx = 3'h0;
					n.nibIdx = 2'h0;
					n.csum = 4'h0;
					n.state = ST_START;
				end
			end
			default: begin
				if (r.rejF) begin
					// Pending stays set so the idle state retries it
					n.state = ST_IDLE;
					if (&r.pend) begin
						n.curBuf = ~r.curBuf;
					end
				end else if (r.stopF || starve) begin
					n.link.frame = 1'b1;
					n.link.ignore = 1'b1;
				end else begin
					emit = 1'b1;
					case (r.state)
						ST_START: begin
							emitNib = nibbleOf(SRC_ONES, curWord, 2'h0,
								r.path, r.csum);
							n.state = ST_ROUTE;
						end
						ST_ROUTE: begin
							emitNib = nibbleOf(SRC_ROUTE, curWord, 2'h0,
								r.path, r.csum);
							n.state = ST_DATA;
						end
						ST_DATA: begin
							emitNib = dataNib;
							n.csum = r.csum ^ dataNib;
							n.nibIdx = r.nibIdx + 2'h1;
							if (r.nibIdx == 2'h3) begin
								if (r.wordIdx >= lastIdx) begin
									n.state = ST_CSUM;
								end else begin
									n.wordIdx = r.wordIdx + 3'h1;
								end
							end
						end
						ST_CSUM: begin
							emitNib = nibbleOf(SRC_CSUM, curWord, 2'h0,
								r.path, r.csum);
							n.state = ST_FINISH;
						end
						default: begin
							emitNib = nibbleOf(SRC_ZERO, curWord, 2'h0,
								r.path, r.csum);
							pendClr[r.curBuf] = 1'b1;
							n.curBuf = ~r.curBuf;
							n.state = ST_IDLE;
						end
					endcase
				end
			end
		endcase
		if (emit) begin
			n.link.frame = 1'b1;
			n.link.data = emitNib;
		end
		// A software set in the same cycle as the hardware clear wins
		n.pend = (r.pend & ~pendClr) | pendSet;
		for (int b = 0; b < 2; b++) begin
			if (pendClr[b]) begin
				n.fill[b] = 3'h0;
			end
		end
		// Only buffer words count as filled; scratch words are left alone
		if (memWr && busReq.addr[3:0] < SCRATCH_BASE) begin
			if (r.fill[busReq.addr[3:0] >= BUF1_BASE] <= wIdx) begin
				n.fill[busReq.addr[3:0] >= BUF1_BASE] = wIdx + 3'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r <= '0;
			r.pend <= RST_PEND;
			r.mask <= RST_MASK;
			r.path <= RST_PATH;
		end else begin
			r <= n;
		end
	end

	assign rdData = r.rdData;
	assign linkOut = r.link;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence sCsumStep;
		r.state == ST_CSUM && !r.rejF && !r.stopF;
	endsequence
	sequence sFinishStep;
		r.state == ST_FINISH;
	endsequence
	sequence sStartStep;
		r.state == ST_START && !r.rejF && !r.stopF;
	endsequence
	sequence sRouteStep;
		r.state == ST_ROUTE;
	endsequence

	chk_idle_start: assert property (
		r.state == ST_IDLE && (|r.pend) && (|r.mask)
		|=> r.state == ST_START && linkOut.frame == 1'b0)
		else $error("pending buffer not started from idle");
	chk_done_clears: assert property (
		r.state == ST_FINISH && !r.rejF && !r.stopF && pendSet == 2'h0
		|=> !r.pend[$past(r.curBuf)] && r.state == ST_IDLE)
		else $error("finished buffer still pending");
	chk_reject_keeps: assert property (
		sending && r.rejF
		|=> r.state == ST_IDLE && r.pend[$past(r.curBuf)])
		else $error("rejected buffer lost its pending flag");
	chk_reject_alternates: assert property (
		sending && r.rejF && (&r.pend)
		|=> r.curBuf != $past(r.curBuf))
		else $error("no buffer switch after rejection");
	chk_path_differs: assert property (
		goNow && $countones(r.mask) > 1 |-> nextPath != r.path)
		else $error("same path chosen twice in a row");
	chk_path_enabled: assert property (
		r.state == ST_START |-> $past(r.mask[nextPath]))
		else $error("attempt on an inhibited path");
	chk_reject_ends: assert property (
		sending && r.rejF |=> !linkOut.frame ##1 !linkOut.frame)
		else $error("message not ended on rejection");
	chk_stop_pause: assert property (
		sending && r.stopF && !r.rejF
		|=> linkOut.frame && linkOut.ignore && linkOut.data == 4'h0)
		else $error("data sent while stop asserted");
	chk_starve_ignore: assert property (
		starve && !r.rejF && !r.stopF
		|=> linkOut.ignore && $stable(r.wordIdx))
		else $error("missing word not flagged as ignored");
	chk_csum_sent: assert property (
		sCsumStep |=> linkOut.data == $past(r.csum) ##0 sFinishStep)
		else $error("checksum nibble wrong");
	chk_route_onehot: assert property (
		r.state == ST_ROUTE && !r.rejF && !r.stopF
		|=> linkOut.data == 4'h1 << r.path && linkOut.frame)
		else $error("route nibble wrong");

	chk_start_route: assert property (
		sStartStep |=> linkOut.data == 4'hf ##0 sRouteStep)
		else $error("start nibble wrong");
	chk_mask_refused: assert property (
		r.state == ST_IDLE && r.mask == 4'h0
		|=> r.state == ST_IDLE && !linkOut.frame)
		else $error("attempt started with every path inhibited");
	chk_path_held: assert property (
		sending |=> $stable(r.path))
		else $error("path changed within an attempt");
	chk_finish_flip: assert property (
		sFinishStep ##0 (!r.rejF && !r.stopF)
		|=> r.curBuf != $past(r.curBuf))
		else $error("buffer not alternated after a message");
	chk_pend_set: assert property (
		busReq.wr && busReq.addr == OFS_PEND
		|=> (r.pend & $past(busReq.wdata[1:0]))
			== $past(busReq.wdata[1:0]))
		else $error("pending bit not set by write");
	chk_scratch_nofill: assert property (
		memWr && busReq.addr[3:0] >= SCRATCH_BASE && pendClr == 2'h0
		|=> $stable(r.fill))
		else $error("scratch write changed a fill count");
	chk_read_idle: assert property (
		!busReq.rd |=> rdData == '0)
		else $error("read data outside its cycle");
endmodule

// >>> tb/switch_model.sv
// Far end switch port model: rejects or stalls a frame on command.
`timescale 1ns/1ps
module switch_model
	import txm_pkg::*;
(
	input wire logic clock, // Bench clock
	input wire link_out_type linkOut, // Nibbles from the transmitter
	input wire logic rejectArm, // Reject the next frame
	input wire logic stopArm, // Stall the next frame
	output link_in_type linkIn // Reject and stop lines back
);
	int nib = 0;
	link_in_type drv = '0;
	assign linkIn = drv;
	always @(posedge clock) begin
		nib <= linkOut.frame ? nib + 1 : 0;
		// Short pulse so the filtered reject is gone before the retry
		drv.reject <= rejectArm && linkOut.frame && nib inside {3, 4};
		drv.stopSend <= stopArm && linkOut.frame && nib inside {[4:8]};
	end
endmodule

// >>> tb/test_switch_message_transmitter.sv
// Self-checking bench of the switch message transmitter.
`timescale 1ns/1ps
module test_switch_message_transmitter;
	import txm_pkg::*;
	typedef struct {
		logic [3:0] route;
		logic [3:0] sum;
		int len;
		bit full;
		bit stall;
	} msg_type;
	logic clock = 0;
	logic rst = 1;
	bus_req_type busReq = '0;
	logic [DATA_W-1:0] rdData;
	link_in_type linkIn;
	link_out_type linkOut;
	logic rejectArm;
	logic stopArm;
	int nFrames = 0;
	int rejAt = -1;
	int stopAt = -1;
	int nMismatch = 0;
	int cmpCount = 0;
	logic [15:0] rdQ[$];
	msg_type msgQ[$];
	msg_type m;
	logic [3:0] nibs[$];
	logic [1:0] path = RST_PATH;
	logic [3:0] mask = RST_MASK;
	int ign = 0;
	logic rdSeen = 0;
	logic inFrame = 0;

	initial forever #10 clock = ~clock;

	// Each arm covers exactly one frame: it drops when that frame ends
	assign rejectArm = rejAt == nFrames;
	assign stopArm = stopAt == nFrames;

	switch_message_transmitter u_switch_message_transmitter (.clock(clock),
		.rst(rst), .busReq(busReq), .rdData(rdData), .linkIn(linkIn),
		.linkOut(linkOut));
	switch_model u_switch_model (.clock(clock), .linkOut(linkOut),
		.rejectArm(rejectArm), .stopArm(stopArm), .linkIn(linkIn));

	task automatic cmpRd(string w, logic [15:0] e, logic [15:0] g);
		cmpCount++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask
	task automatic cmpMsg(string w, logic [7:0] e, logic [7:0] g);
		cmpCount++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
		if (nMismatch == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(logic [4:0] a, logic [15:0] d, logic [1:0] be = 2'h3);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, byteEn: be, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a, logic [15:0] e);
		rdQ.push_back(e);
		@(posedge clock);
		busReq <= '{addr: a, wdata: '0, byteEn: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
	endtask
	function automatic logic [1:0] nxt(logic [1:0] p, logic [3:0] k);
		logic [1:0] q;
		q = p;
		for (int j = 0; j < 4; j++) begin
			q = q + 2'h1;
			if (k[q])
				return q;
		end
		return p;
	endfunction
	task automatic expMsg(logic [3:0] s, int l, bit f, bit st);
		path = nxt(path, mask);
		msgQ.push_back('{4'h1 << path, s, l, f, st});
	endtask
	// Late mode marks the buffer pending before its last word exists
	task automatic load(bit b, logic [2:0] c, bit late,
		output logic [3:0] s, output int l);
		logic [15:0] w;
		s = 4'h0;
		for (int k = 0; k <= c; k++) begin
			w = 16'($urandom);
			if (k == 0)
				w[2:0] = c;
			s ^= w[3:0] ^ w[7:4] ^ w[11:8] ^ w[15:12];
			if (late && k == c) begin
				wr(OFS_PEND, b ? 16'h2 : 16'h1);
				repeat (20) @(posedge clock);
			end
			wr((b ? {1'b0, BUF1_BASE} : 5'h00) + 5'(k), w);
		end
		l = 4 * (c + 1) + 4;
	endtask
	task automatic drain();
		for (int k = 0; k < 3000 && msgQ.size() > 0; k++)
			@(posedge clock);
		if (msgQ.size() > 0) begin
			nMismatch++;
			conclude();
		end
		repeat (2) @(posedge clock);
	endtask

	always @(posedge clock) begin
		if (rdSeen)
			cmpRd("read data", rdQ.pop_front(), rdData);
		rdSeen <= busReq.rd;
		if (linkOut.frame) begin
			inFrame <= 1'b1;
			if (linkOut.ignore) begin
				ign++;
				cmpMsg("ignored nibble", 8'h0, {4'h0, linkOut.data});
			end else
				nibs.push_back(linkOut.data);
		end else if (inFrame) begin
			inFrame <= 1'b0;
			m = msgQ.pop_front();
			cmpMsg("start", 8'h0f, {4'h0, nibs[0]});
			cmpMsg("route", {4'h0, m.route}, {4'h0, nibs[1]});
			if (m.full) begin
				cmpMsg("length", 8'(m.len), 8'(nibs.size()));
				cmpMsg("sum", {4'h0, m.sum}, {4'h0, nibs[nibs.size()-2]});
				cmpMsg("stall", 8'(m.stall), 8'(ign > 0));
			end else
				cmpMsg("cut", 8'h1, 8'(nibs.size() < m.len));
			nibs.delete();
			ign = 0;
			nFrames <= nFrames + 1;
		end
	end

	initial begin
		logic [3:0] s0;
		logic [3:0] s1;
		int l0;
		int l1;
		void'($urandom(32'h0682));
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rd(OFS_PEND, 16'h0000);
		rd(OFS_MASK, {12'h0, RST_MASK});
		wr(OFS_STATUS, 16'hffff);
		rd(OFS_STATUS, {11'h0, 1'b0, RST_PATH, 2'h0});
		rd(5'h13, 16'h0000);
		wr(5'h0c, 16'hffff);
		wr(5'h0c, 16'h1234, 2'h1);
		wr(5'h0c, 16'h5678, 2'h2);
		rd(5'h0c, 16'h5634);
		wr(OFS_MEM_LAST, 16'ha5c3);
		rd(OFS_MEM_LAST, 16'ha5c3);
		$display("test registers done");
		load(0, 1, 0, s0, l0);
		expMsg(s0, l0, 1, 0);
		wr(OFS_PEND, 16'h0001);
		drain();
		rd(OFS_PEND, 16'h0000);
		$display("test single message done");
		mask = 4'ha;
		wr(OFS_MASK, 16'h000a);
		rd(OFS_MASK, 16'h000a);
		load(1, 0, 0, s1, l1);
		expMsg(s1, l1, 1, 0);
		wr(OFS_PEND, 16'h0002);
		drain();
		load(0, 5, 0, s0, l0);
		expMsg(s0, l0, 1, 0);
		wr(OFS_PEND, 16'h0001);
		drain();
		mask = 4'hf;
		wr(OFS_MASK, 16'h000f);
		$display("test path mask done");
		load(1, 2, 0, s1, l1);
		stopAt <= nFrames;
		expMsg(s1, l1, 1, 1);
		wr(OFS_PEND, 16'h0002);
		drain();
		$display("test stop sending done");
		// Buffer 0 is tried first, rejected, then buffer 1 goes ahead
		load(0, 2, 0, s0, l0);
		load(1, 1, 0, s1, l1);
		rejAt <= nFrames;
		expMsg(s0, l0, 0, 0);
		expMsg(s1, l1, 1, 0);
		expMsg(s0, l0, 1, 0);
		wr(OFS_PEND, 16'h0003);
		drain();
		rd(OFS_PEND, 16'h0000);
		$display("test reject done");
		load(1, 1, 1, s1, l1);
		expMsg(s1, l1, 1, 1);
		drain();
		rd(OFS_PEND, 16'h0000);
		$display("test late data done");
		// With every path inhibited a pending buffer must wait
		mask = 4'h0;
		wr(OFS_MASK, 16'h0000);
		load(0, 0, 0, s0, l0);
		wr(OFS_PEND, 16'h0001);
		repeat (30) @(posedge clock);
		rd(OFS_PEND, 16'h0001);
		rd(OFS_STATUS, {11'h0, 1'b0, path, 2'h0});
		mask = 4'h4;
		expMsg(s0, l0, 1, 0);
		wr(OFS_MASK, 16'h0004);
		drain();
		rd(OFS_PEND, 16'h0000);
		$display("test mask refused done");
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		path = RST_PATH;
		mask = RST_MASK;
		rd(OFS_MASK, {12'h0, mask});
		rd(OFS_STATUS, {11'h0, 1'b0, path, 2'h0});
		rd(OFS_PEND, 16'h0000);
		$display("test reset again done");
		conclude();
	end
endmodule
